// ===== aclr_pkg.sv
// register map, field positions and timing constants of the link controller
// assumes a 100 MHz system clock and a 32-bit APB register bus
package aclr_pkg;
  localparam logic [11:0] OFF_MODE = 12'h008;
  localparam logic [11:0] OFF_ICA = 12'h010;
  localparam logic [11:0] OFF_OCA = 12'h014;
  localparam logic [11:0] OFF_A_RX = 12'h020;
  localparam logic [11:0] OFF_A_TX = 12'h024;
  localparam logic [11:0] OFF_A_ST = 12'h028;
  localparam logic [11:0] OFF_A_CFG = 12'h02c;
  localparam logic [11:0] OFF_B_RX = 12'h030;
  localparam logic [11:0] OFF_B_TX = 12'h034;
  localparam logic [11:0] OFF_B_ST = 12'h038;
  localparam logic [11:0] OFF_B_CFG = 12'h03c;
  localparam logic [11:0] OFF_C_RX = 12'h040;
  localparam logic [11:0] OFF_C_TX = 12'h044;
  localparam logic [11:0] OFF_C_ST = 12'h048;
  localparam logic [11:0] OFF_C_CFG = 12'h04c;
  localparam logic [11:0] OFF_GSTAT = 12'h050;
  localparam logic [11:0] OFF_IER = 12'h054;
  localparam logic [11:0] OFF_IDR = 12'h058;
  localparam logic [11:0] OFF_IMR = 12'h05c;
  localparam logic [11:0] OFF_DMA_LO = 12'h100;
  localparam logic [11:0] OFF_DMA_HI = 12'h124;
  // mode register fields
  localparam int MODE_ON_BIT = 0;
  localparam int MODE_WARM_BIT = 1;
  localparam int MODE_VAR_BIT = 2;
  localparam logic [2:0] MODE_RST = 3'h0;
  // global state fields
  localparam int ST_SOF_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_CA_BIT = 2;
  localparam int ST_CB_BIT = 3;
  localparam int ST_CO_BIT = 4;
  localparam int ST_W = 5;
  localparam logic [4:0] ST_RST = 5'h00;
  // channel status fields
  localparam int CH_TXRDY_BIT = 0;
  localparam int CH_TXEMPTY_BIT = 1;
  localparam int CH_RXRDY_BIT = 4;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [19:0] SLOT_RST = 20'h00000;
  localparam int ASSIGN_W = 30;
  localparam int SLOT_W = 20;
  // link framing: 256 bit clocks per frame, 16-bit tag, 12 slots of 20
  localparam logic [7:0] FRAME_LAST = 8'hff;
  localparam logic [7:0] TAG_LAST = 8'h0f;
  // warm reset pulse length
  localparam int WARM_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int WARM_CYC = (WARM_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] WARM_CNT = 8'(WARM_CYC);
endpackage : aclr_pkg

// ===== aclr_ctrl.sv
// link controller register set, mode control and frame timing
// assumes an APB master on i_clk; codec bit clock arrives as a plain pin
// Overview of operation
// - start of frame after wake sets flag, irq
// - mode bit 2 selects variable rate slots
// - mode bit 1 drives warm reset on link
// - mode bit 0 enables link and registers
// - offsets 0x100 to 0x124 kept for dma
// - warm reset holds frame sync high while mode bit 1 is set
// - variable rate: slot 1 requests fill slots
`timescale 1ns/1ps
`default_nettype none
module aclr_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_codec_bit_clock,
  input wire logic i_sdata_in,
  output logic o_sdata_out,
  output logic o_frame_sync_line,
  output logic o_variable_rate_select,
  output logic o_irq
);
  // pin synchronisers
  logic [2:0] bclk_sync_q;
  logic [2:0] din_sync_q;
  logic bclk_lvl_q;
  logic din_lvl_q;
  // registers
  logic [2:0] mode_q;
  logic [aclr_pkg::ASSIGN_W-1:0] ica_q;
  logic [aclr_pkg::ASSIGN_W-1:0] oca_q;
  logic [31:0] a_cfg_q;
  logic [31:0] b_cfg_q;
  logic [31:0] c_cfg_q;
  logic [aclr_pkg::SLOT_W-1:0] a_rx_q;
  logic [aclr_pkg::SLOT_W-1:0] b_rx_q;
  logic [15:0] c_rx_q;
  logic [aclr_pkg::SLOT_W-1:0] a_tx_q;
  logic [aclr_pkg::SLOT_W-1:0] b_tx_q;
  logic [23:0] c_tx_q;
  logic a_txfull_q;
  logic b_txfull_q;
  logic c_txfull_q;
  logic a_rxrdy_q;
  logic b_rxrdy_q;
  logic c_rxrdy_q;
  logic [aclr_pkg::ST_W-1:0] stat_q;
  logic [aclr_pkg::ST_W-1:0] imr_q;
  logic woke_q;
  logic [7:0] warm_cnt_q;
  // link framing
  logic [7:0] bit_cnt_q;
  logic [aclr_pkg::SLOT_W-1:0] rx_shift_q;
  logic [aclr_pkg::SLOT_W-1:0] tx_shift_q;
  logic [11:0] req_q;
  logic sout_q;
  logic fs_q;
  logic [3:0] slot_idx;
  logic [4:0] slot_bit;

  // pins pass three flops, a level counts when second and third agree
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bclk_sync_q <= 3'h0;
      din_sync_q <= 3'h0;
      bclk_lvl_q <= 1'b0;
      din_lvl_q <= 1'b0;
    end
    else
    begin
      bclk_sync_q <= {bclk_sync_q[1:0], i_codec_bit_clock};
      din_sync_q <= {din_sync_q[1:0], i_sdata_in};
      if (bclk_sync_q[1] == bclk_sync_q[2])
        bclk_lvl_q <= bclk_sync_q[2];
      if (din_sync_q[1] == din_sync_q[2])
        din_lvl_q <= din_sync_q[2];
    end
  end

  // edge detection on the filtered bit clock
  wire bclk_new = (bclk_sync_q[1] == bclk_sync_q[2]) ? bclk_sync_q[2]
    : bclk_lvl_q;
  wire bclk_rise = bclk_new & ~bclk_lvl_q;
  wire bclk_fall = ~bclk_new & bclk_lvl_q;

  // mode fields
  wire ctl_on = mode_q[aclr_pkg::MODE_ON_BIT];
  wire warm_on = mode_q[aclr_pkg::MODE_WARM_BIT];
  wire var_rate = mode_q[aclr_pkg::MODE_VAR_BIT];

  // apb decode, always zero wait states
  wire [11:0] addr = i_paddr[11:0];
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite;
  wire rd = acc & ~i_pwrite;
  wire hi_zero = (i_paddr[31:12] == 20'h00000);
  wire hit_mode = hi_zero && addr == aclr_pkg::OFF_MODE;
  // other registers reachable only while enabled
  wire gate = hi_zero & ctl_on;
  wire hit_ica = gate && addr == aclr_pkg::OFF_ICA;
  wire hit_oca = gate && addr == aclr_pkg::OFF_OCA;
  wire hit_arx = gate && addr == aclr_pkg::OFF_A_RX;
  wire hit_atx = gate && addr == aclr_pkg::OFF_A_TX;
  wire hit_ast = gate && addr == aclr_pkg::OFF_A_ST;
  wire hit_acf = gate && addr == aclr_pkg::OFF_A_CFG;
  wire hit_brx = gate && addr == aclr_pkg::OFF_B_RX;
  wire hit_btx = gate && addr == aclr_pkg::OFF_B_TX;
  wire hit_bst = gate && addr == aclr_pkg::OFF_B_ST;
  wire hit_bcf = gate && addr == aclr_pkg::OFF_B_CFG;
  wire hit_crx = gate && addr == aclr_pkg::OFF_C_RX;
  wire hit_ctx = gate && addr == aclr_pkg::OFF_C_TX;
  wire hit_cst = gate && addr == aclr_pkg::OFF_C_ST;
  wire hit_ccf = gate && addr == aclr_pkg::OFF_C_CFG;
  wire hit_gst = gate && addr == aclr_pkg::OFF_GSTAT;
  wire hit_ier = gate && addr == aclr_pkg::OFF_IER;
  wire hit_idr = gate && addr == aclr_pkg::OFF_IDR;
  wire hit_imr = gate && addr == aclr_pkg::OFF_IMR;
  // dma window is held back and reads zero here
  wire hit_dma = hi_zero && addr >= aclr_pkg::OFF_DMA_LO
    && addr <= aclr_pkg::OFF_DMA_HI;

  // channel status words
  // transmit flags read zero until the channel is configured
  wire a_txe = (|a_cfg_q) & ~a_txfull_q;
  wire b_txe = (|b_cfg_q) & ~b_txfull_q;
  wire c_txe = (|c_cfg_q) & ~c_txfull_q;
  wire [31:0] a_st = {27'h0, a_rxrdy_q, 2'h0, a_txe, a_txe};
  wire [31:0] b_st = {27'h0, b_rxrdy_q, 2'h0, b_txe, b_txe};
  wire [31:0] c_st = {27'h0, c_rxrdy_q, 2'h0, c_txe, c_txe};

  // read mux, unmapped and reserved read zero
  assign o_prdata =
    hit_dma ? aclr_pkg::WORD_RST :
    hit_mode ? {29'h0, mode_q} :
    hit_ica ? {2'h0, ica_q} :
    hit_oca ? {2'h0, oca_q} :
    hit_arx ? {12'h0, a_rx_q} :
    hit_ast ? a_st :
    hit_acf ? a_cfg_q :
    hit_brx ? {12'h0, b_rx_q} :
    hit_bst ? b_st :
    hit_bcf ? b_cfg_q :
    hit_crx ? {16'h0, c_rx_q} :
    hit_cst ? c_st :
    hit_ccf ? c_cfg_q :
    hit_gst ? {27'h0, stat_q} :
    hit_imr ? {27'h0, imr_q} :
    aclr_pkg::WORD_RST;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_irq = |(stat_q & imr_q);
  assign o_variable_rate_select = var_rate;
  assign o_sdata_out = sout_q;
  // warm reset drives sync high regardless of bit clock
  assign o_frame_sync_line = warm_on | fs_q;
  assign slot_idx = (bit_cnt_q <= aclr_pkg::TAG_LAST) ? 4'h0
    : 4'((bit_cnt_q - 8'h10) / 8'd20 + 8'd1);
  assign slot_bit = (bit_cnt_q <= aclr_pkg::TAG_LAST) ? 5'h0
    : 5'((bit_cnt_q - 8'h10) % 8'd20);
  wire slot_end = (slot_idx != 4'h0) && slot_bit == 5'd19;
  wire tag_end = bit_cnt_q == aclr_pkg::TAG_LAST;
  wire frame_end = bit_cnt_q == aclr_pkg::FRAME_LAST;
  wire link_run = ctl_on & ~warm_on;
  // channel assignment of the current data slot (3..12)
  wire [3:0] dslot = slot_idx - 4'd3;
  wire data_slot = slot_idx >= 4'd3;
  wire [2:0] ica_sel = 3'(ica_q >> (dslot * 3));
  wire [2:0] oca_sel = 3'(oca_q >> (dslot * 3));
  wire rx_done = bclk_fall & link_run & slot_end;
  wire sof_evt = bclk_rise & link_run & frame_end & woke_q;
  // write data of the event and mask registers
  wire [aclr_pkg::ST_W-1:0] st_wdat = i_pwdata[aclr_pkg::ST_W-1:0];
  wire [aclr_pkg::ST_W-1:0] st_clr = (wr && hit_gst) ? st_wdat : 5'h0;

  // mode register, writable whatever the enable state
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      mode_q <= aclr_pkg::MODE_RST;
    else if (wr && hit_mode)
      mode_q <= i_pwdata[2:0];
  end

  // assignment and config registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ica_q <= '0;
      oca_q <= '0;
      a_cfg_q <= aclr_pkg::WORD_RST;
      b_cfg_q <= aclr_pkg::WORD_RST;
      c_cfg_q <= aclr_pkg::WORD_RST;
    end
    else if (wr)
    begin
      if (hit_ica) ica_q <= i_pwdata[aclr_pkg::ASSIGN_W-1:0];
      if (hit_oca) oca_q <= i_pwdata[aclr_pkg::ASSIGN_W-1:0];
      if (hit_acf) a_cfg_q <= i_pwdata;
      if (hit_bcf) b_cfg_q <= i_pwdata;
      if (hit_ccf) c_cfg_q <= i_pwdata;
    end
  end

  // warm reset length and wake tracking; sof only after a wake
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      warm_cnt_q <= 8'h00;
      woke_q <= 1'b0;
    end
    else
    begin
      if (warm_on && warm_cnt_q != aclr_pkg::WARM_CNT)
        warm_cnt_q <= warm_cnt_q + 8'h01;
      else if (!warm_on)
        warm_cnt_q <= 8'h00;
      if (warm_on && warm_cnt_q == aclr_pkg::WARM_CNT)
        woke_q <= 1'b1;
      else if (sof_evt)
        woke_q <= 1'b0;
    end
  end

  // sticky events and mask, set beats clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      stat_q <= aclr_pkg::ST_RST;
      imr_q <= aclr_pkg::ST_RST;
    end
    else
    begin
      stat_q <= (stat_q & ~st_clr)
        | {c_rxrdy_q, b_rxrdy_q, a_rxrdy_q,
           bclk_rise & din_lvl_q & ~link_run, sof_evt};
      if (wr && hit_ier) imr_q <= imr_q | st_wdat;
      else if (wr && hit_idr) imr_q <= imr_q & ~st_wdat;
    end
  end

  // bit counter, frame sync and shift registers on bit clock edges
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !link_run)
    begin
      bit_cnt_q <= 8'h00;
      fs_q <= 1'b0;
      sout_q <= 1'b0;
      rx_shift_q <= aclr_pkg::SLOT_RST;
      tx_shift_q <= aclr_pkg::SLOT_RST;
    end
    else if (bclk_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 8'h01;
      fs_q <= (bit_cnt_q == aclr_pkg::FRAME_LAST)
        || (bit_cnt_q < aclr_pkg::TAG_LAST);
      sout_q <= tx_shift_q[aclr_pkg::SLOT_W-1];
      tx_shift_q <= {tx_shift_q[aclr_pkg::SLOT_W-2:0], 1'b0};
      // tag end loads slot 1, slot 12 end wraps to the next tag
      if (frame_end || tag_end || slot_end)
        tx_shift_q <= tx_load(slot_idx == 4'd12 ? 4'd0 : slot_idx + 4'd1);
    end
    else if (bclk_fall)
      rx_shift_q <= {rx_shift_q[aclr_pkg::SLOT_W-2:0], din_lvl_q};
  end

  // payload of next slot; variable rate only sends requested data slots 3..12, tag and slots 1, 2 always
  function automatic logic [aclr_pkg::SLOT_W-1:0] tx_load(
    input logic [3:0] s);
    logic [2:0] sel;
    logic ok;
    sel = 3'(oca_q >> ((s - 4'd3) * 3));
    // flag of slot s sits at bit 14 - s of the request word, low active
    ok = !var_rate || (s >= 4'd3 && !req_q[4'd14 - s]);
    tx_load = aclr_pkg::SLOT_RST;
    if (s == 4'd0)
      tx_load = {a_txfull_q | b_txfull_q, c_txfull_q, c_txfull_q, 17'h0};
    else if (s == 4'd1)
      tx_load = {c_tx_q[23:16], 12'h000};
    else if (s == 4'd2)
      tx_load = {c_tx_q[15:0], 4'h0};
    else if (s >= 4'd3 && ok && sel == 3'd1)
      tx_load = a_tx_q;
    else if (s >= 4'd3 && ok && sel == 3'd2)
      tx_load = b_tx_q;
  endfunction

  // holding registers, full flags and receive captures
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      a_tx_q <= aclr_pkg::SLOT_RST;
      b_tx_q <= aclr_pkg::SLOT_RST;
      c_tx_q <= 24'h000000;
      a_txfull_q <= 1'b0;
      b_txfull_q <= 1'b0;
      c_txfull_q <= 1'b0;
      a_rx_q <= aclr_pkg::SLOT_RST;
      b_rx_q <= aclr_pkg::SLOT_RST;
      c_rx_q <= 16'h0000;
      a_rxrdy_q <= 1'b0;
      b_rxrdy_q <= 1'b0;
      c_rxrdy_q <= 1'b0;
      req_q <= 12'hfff;
    end
    else
    begin
      if (wr && hit_atx) a_tx_q <= i_pwdata[aclr_pkg::SLOT_W-1:0];
      if (wr && hit_btx) b_tx_q <= i_pwdata[aclr_pkg::SLOT_W-1:0];
      if (wr && hit_ctx) c_tx_q <= i_pwdata[23:0];
      if (wr && hit_atx) a_txfull_q <= 1'b1;
      else if (bclk_rise && link_run && frame_end) a_txfull_q <= 1'b0;
      if (wr && hit_btx) b_txfull_q <= 1'b1;
      else if (bclk_rise && link_run && frame_end) b_txfull_q <= 1'b0;
      if (wr && hit_ctx) c_txfull_q <= 1'b1;
      else if (bclk_rise && link_run && frame_end) c_txfull_q <= 1'b0;
      // slot 1 of input frame carries request flags, active low
      if (rx_done && slot_idx == 4'd1 && var_rate)
        req_q <= {rx_shift_q[aclr_pkg::SLOT_W-10:0], din_lvl_q};
      // status data is bits 19..4 of slot 2
      if (rx_done && slot_idx == 4'd2)
        c_rx_q <= rx_shift_q[aclr_pkg::SLOT_W-2:3];
      if (rx_done && data_slot && ica_sel == 3'd1)
        a_rx_q <= {rx_shift_q[aclr_pkg::SLOT_W-2:0], din_lvl_q};
      if (rx_done && data_slot && ica_sel == 3'd2)
        b_rx_q <= {rx_shift_q[aclr_pkg::SLOT_W-2:0], din_lvl_q};
      if (rx_done && slot_idx == 4'd2) c_rxrdy_q <= 1'b1;
      else if (rd && hit_crx) c_rxrdy_q <= 1'b0;
      if (rx_done && data_slot && ica_sel == 3'd1) a_rxrdy_q <= 1'b1;
      else if (rd && hit_arx) a_rxrdy_q <= 1'b0;
      if (rx_done && data_slot && ica_sel == 3'd2) b_rxrdy_q <= 1'b1;
      else if (rd && hit_brx) b_rxrdy_q <= 1'b0;
    end
  end
endmodule // aclr_ctrl
`default_nettype wire

// ===== aclr_ctrl_checker.sv
// assertions on the link controller register port and frame sync pin
// bound to aclr_ctrl, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module aclr_ctrl_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_codec_bit_clock,
  input wire logic i_sdata_in,
  input wire logic o_sdata_out,
  input wire logic o_frame_sync_line,
  input wire logic o_variable_rate_select,
  input wire logic o_irq
);
  logic [2:0] mode_q;
  logic [2:0] mode_d;
  // bus decode
  wire logic acc = i_psel & i_penable;
  wire logic wr = acc & i_pwrite;
  wire logic rd = acc & ~i_pwrite;
  wire logic mode_hit = i_paddr == 32'(aclr_pkg::OFF_MODE);
  wire logic mwr = wr & mode_hit;
  wire logic idr_hit = i_paddr == 32'(aclr_pkg::OFF_IDR);
  // shadow of the mode register
  assign mode_d = mwr ? i_pwdata[2:0] : mode_q;
  always_ff @(posedge i_clk)
    mode_q <= i_rst_n ? mode_d : 3'h0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  zero_wait_a: assert property (acc |-> o_pready && !o_pslverr)
    else $error("slave stalled or flagged an error");
  var_rate_pin_a: assert property (
    mwr |-> ##2 o_variable_rate_select == mode_q[2])
    else $error("rate select pin differs from mode");
  warm_sync_high_a: assert property (
    mwr && i_pwdata[1] |-> ##[1:2] o_frame_sync_line)
    else $error("frame sync not raised by warm reset");
  warm_sync_hold_a: assert property (
    mwr && i_pwdata[1] |-> ##2 o_frame_sync_line [*8])
    else $error("frame sync dropped during warm reset");
  warm_sync_drop_a: assert property (
    mwr && i_pwdata[1:0] == 2'b00 |-> ##[1:3] !o_frame_sync_line)
    else $error("frame sync high with link off");
  reserved_zero_a: assert property (
    rd && (i_paddr >= 32'h60 || i_paddr < 32'h8) |-> o_prdata == 32'h0)
    else $error("reserved offset read nonzero");
  off_read_zero_a: assert property (
    rd && !mode_q[0] && !mode_hit |-> o_prdata == 32'h0)
    else $error("register readable while disabled");
  mode_read_back_a: assert property (
    rd && mode_hit |-> o_prdata == {29'h0, mode_q})
    else $error("mode read differs from written value");
  irq_masked_a: assert property (
    wr && mode_q[0] && idr_hit && i_pwdata[4:0] == 5'h1f |-> ##[1:2] !o_irq)
    else $error("interrupt high with all sources masked");
endmodule // aclr_ctrl_checker
bind aclr_ctrl aclr_ctrl_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_codec_bit_clock(i_codec_bit_clock), .i_sdata_in(i_sdata_in),
  .o_sdata_out(o_sdata_out), .o_frame_sync_line(o_frame_sync_line),
  .o_variable_rate_select(o_variable_rate_select), .o_irq(o_irq));
`default_nettype wire

// ===== aclr_codec_model.sv
// behavioural codec: bit clock source, input line, warm wake-up
// bench raises i_sleep to power the codec down
`timescale 1ns/1ps
`default_nettype none
module aclr_codec_model (
  input wire logic i_sync,
  input wire logic i_sleep,
  output logic o_bclk,
  output logic o_sdata
);
  logic asleep = 1'b0;
  realtime t_hi = 0.0;
  // power down on request, wake on a long sync pulse
  always @(posedge i_sleep) asleep = 1'b1;
  always @(posedge i_sync) t_hi = $realtime;
  always @(negedge i_sync)
    if (asleep && $realtime - t_hi >= 1000.0) asleep = 1'b0;
  // 80 ns bit clock, held low while asleep, phase unrelated
  initial
  begin
    o_bclk = 1'b0;
    #17;
    forever #40 o_bclk = asleep ? 1'b0 : ~o_bclk;
  end
  // input line held low, slot data all zero
  assign o_sdata = 1'b0;
endmodule // aclr_codec_model
`default_nettype wire

// ===== aclr_ctrl_tb.sv
// self-checking bench for the controller registers and warm reset
// APB master on the rising edge, codec model supplies the bit clock
`timescale 1ns/1ps
`default_nettype none
module aclr_ctrl_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] padr = 32'h0;
  logic [31:0] pwd = 32'h0;
  logic sleep = 1'b0;
  logic [31:0] r;
  wire logic [31:0] prd;
  wire logic rdy, bclk, sdin, sync, vrs, irq, sout;
  int fails = 0;
  int samples_checked = 0;
  always #5 i_clk = ~i_clk;
  aclr_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(),
    .i_codec_bit_clock(bclk), .i_sdata_in(sdin), .o_sdata_out(sout),
    .o_frame_sync_line(sync), .o_variable_rate_select(vrs), .o_irq(irq));
  aclr_codec_model codec (.i_sync(sync), .i_sleep(sleep), .o_bclk(bclk),
    .o_sdata(sdin));
  // verdict and end of run
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {20'h0, a};
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do
    begin
      @(posedge i_clk);
    end
    while (rdy !== 1'b1);
    r = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // writes ignored while off, enable reachable
  task automatic t_off;
    wr(aclr_pkg::OFF_ICA, 32'h1);
    rdc(aclr_pkg::OFF_ICA, 32'h0);
    rdc(aclr_pkg::OFF_MODE, 32'h0);
    wr(aclr_pkg::OFF_MODE, 32'h1);
    rdc(aclr_pkg::OFF_ICA, 32'h0);
  endtask
  // reset values of readable registers
  task automatic t_rst;
    logic [11:0] a [12] = '{12'h014, 12'h020, 12'h028, 12'h02c, 12'h030,
      12'h038, 12'h03c, 12'h040, 12'h048, 12'h04c, 12'h050, 12'h05c};
    foreach (a[i]) rdc(a[i], 32'h0);
  endtask
  // read-write storage and unused bits
  task automatic t_rw;
    logic [11:0] a [5] = '{12'h010, 12'h014, 12'h02c, 12'h03c, 12'h04c};
    foreach (a[i])
    begin
      wr(a[i], 32'hffff_ffff);
      rdc(a[i], i < 2 ? 32'h3fff_ffff : 32'hffff_ffff);
    end
  endtask
  // reserved and dma offsets
  task automatic t_rsv;
    logic [11:0] a [9] = '{12'h000, 12'h004, 12'h00c, 12'h018, 12'h01c,
      12'h060, 12'h0fc, 12'h100, 12'h124};
    foreach (a[i])
    begin
      wr(a[i], 32'hffff_ffff);
      rdc(a[i], 32'h0);
    end
    rdc(aclr_pkg::OFF_MODE, 32'h1);
  endtask
  // variable rate bit and pin
  task automatic t_vrate;
    wr(aclr_pkg::OFF_MODE, 32'h5);
    wt(2);
    chk({31'h0, vrs}, 32'h1);
    rdc(aclr_pkg::OFF_MODE, 32'h5);
    wr(aclr_pkg::OFF_MODE, 32'h1);
    wt(2);
    chk({31'h0, vrs}, 32'h0);
  endtask
  // warm reset, start of frame flag, mask and clear
  task automatic t_warm;
    wr(aclr_pkg::OFF_IER, 32'h1);
    sleep <= 1'b1;
    wt(10);
    wr(aclr_pkg::OFF_MODE, 32'h3);
    wt(3);
    chk({31'h0, sync}, 32'h1);
    wt(105);
    chk({31'h0, sync}, 32'h1);
    wr(aclr_pkg::OFF_MODE, 32'h1);
    sleep <= 1'b0;
    repeat (6000) if (irq !== 1'b1) @(posedge i_clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, aclr_pkg::OFF_GSTAT, 32'h0);
    chk(r & 32'h1, 32'h1);
    wr(aclr_pkg::OFF_IDR, 32'h1f);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    rdc(aclr_pkg::OFF_IMR, 32'h0);
    wr(aclr_pkg::OFF_IER, 32'h1);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    wr(aclr_pkg::OFF_GSTAT, 32'h1);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    wr(aclr_pkg::OFF_MODE, 32'h0);
    wt(3);
    chk({31'h0, sync}, 32'h0);
  endtask
  // channel a data fills slot 3, fixed then variable rate
  task automatic t_link;
    int run;
    run = 0;
    wr(aclr_pkg::OFF_MODE, 32'h1);
    wr(aclr_pkg::OFF_OCA, 32'h1);
    wr(aclr_pkg::OFF_A_TX, 32'h000f_ffff);
    repeat (6000)
      if (run < 100)
      begin
        @(posedge i_clk);
        run = (sout === 1'b1) ? run + 1 : 0;
      end
    chk(32'(run), 32'h64);
    run = 0;
    wr(aclr_pkg::OFF_MODE, 32'h5);
    repeat (6000)
      if (run < 100)
      begin
        @(posedge i_clk);
        run = (sout === 1'b1) ? run + 1 : 0;
      end
    chk(32'(run), 32'h64);
    wr(aclr_pkg::OFF_MODE, 32'h0);
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_off;
    t_rst;
    t_rw;
    t_rsv;
    t_vrate;
    t_warm;
    t_link;
    print_verdict;
  end
  // watchdog
  initial
  begin
    #500000;
    fails++;
    print_verdict;
  end
endmodule // aclr_ctrl_tb
`default_nettype wire
